// File: logic/bio_defs.svh
// offsets, field positions, reset values and timing counts for the byte i/o controller
// assumes a 32-bit apb slave with one aligned word per register and a 40 ns pclk
`ifndef BIO_DEFS_SVH
`define BIO_DEFS_SVH

// register byte addresses
`define BIO_REG_CTRL        8'h00
`define BIO_REG_STATUS      8'h04
`define BIO_REG_OUT_DATA    8'h08
`define BIO_REG_IN_DATA     8'h0c
`define BIO_REG_FUNC        8'h10
`define BIO_REG_CMD         8'h14

// control register fields
`define BIO_CTRL_ADDR_LSB   0
`define BIO_CTRL_READY_BIT  8
`define BIO_CTRL_DEVB_LSB   12
`define BIO_CTRL_FMASK_LSB  16

// command register bits
`define BIO_CMD_BLK_END_BIT 0
`define BIO_CMD_ERROR_BIT   1

// function mask: order 1 always a function, order 0 never
`define BIO_FMASK_RESET     8'h02
`define BIO_FMASK_FORCE_SET 8'h02
`define BIO_FMASK_FORCE_CLR 8'h01

// first bus address kept for standard units
`define BIO_ADDR_RESERVED   5'h16

// bus timing
`define BIO_CLK_NS          40
`define BIO_SETUP_NS        220
`define BIO_STROBE_NS       880
`define BIO_DO_MAX_NS       4400
`define BIO_DO_MAX_CYC      ((`BIO_DO_MAX_NS) / (`BIO_CLK_NS))

`endif

// File: logic/bio_pkg.sv
// types shared by the byte i/o device controller
// assumes bio_defs.svh is compiled alongside
package bio_pkg;

  // three-bit device order, in code order 0 to 7
  typedef enum logic [2:0] {
    bio_ord_data,
    bio_ord_status,
    bio_ord_blk_in,
    bio_ord_blk_in_irq,
    bio_ord_stop,
    bio_ord_protect,
    bio_ord_blk_out,
    bio_ord_blk_out_irq
  } bio_order_t;

  // byte bus lines into the controller, all active low
  typedef struct packed {
    logic       co_n;
    logic       do_n;
    logic       di_n;
    logic       master_reset_n_n;
    logic [7:0] data_n;
  } bio_bus_in_t;

  // concurrent block transfer state
  typedef struct packed {
    logic active;
    logic dir_out;
    logic irq_at_end;
    logic protect;
  } bio_block_t;

  // whole controller state
  typedef struct packed {
    bio_bus_in_t s1;
    bio_bus_in_t s2;
    bio_bus_in_t prev;
    logic        connected;
    bio_order_t  order;
    logic [7:0]  out_byte;
    logic [7:0]  in_byte;
    logic [7:0]  func_byte;
    logic [2:0]  func_code;
    logic        func_pulse;
    logic        out_pulse;
    logic        input_flag;
    logic        output_flag;
    logic        error;
    bio_block_t  blk;
    logic        end_irq;
    logic        ext_irq;
    logic [7:0]  timer;
    logic [7:0]  drive_n;
    logic [4:0]  dev_addr;
    logic        ready;
    logic [3:0]  dev_bits;
    logic [7:0]  func_mask;
    logic [31:0] prdata;
    logic        pslverr;
  } bio_state_t;

endpackage

// File: logic/bio_byte_io_dev.sv
// byte i/o bus device controller with an apb register port
// assumes bus lines are asynchronous to pclk and the processor keeps its strobe timing
//
// Operation
// - compare address on strobe, connect, keep order
// - decode qualified by strobe, flag on strobes
// - stay connected until one transfer strobe
// - connect plus strobe loads byte, rise disconnects
// - order 0 is data transfer
// - order 1 status in, function out
// - orders 2,3 start block input
// - orders 6,7 start block output
// - order 4 stops block, external interrupt
// - order 5 protect write until transfer end
// - status byte on input data lines
// - bits 0-2: ready, input, output flags
// - bit 3 error, cleared after status read
// - bits 4-7 device specific
// - function output order selects function
// - function codes never used for data
// - function data byte kept as parameter
// - avoid reserved addresses 16 to 1f
// - unique five-bit address per controller
// - master reset clears control flip-flops
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "bio_defs.svh"
`default_nettype none

module bio_byte_io_dev #(
  parameter logic [4:0] DEV_ADDR    = 5'h01,           // reset bus address
  parameter int         DO_WAIT_CYC = `BIO_DO_MAX_CYC  // cycles allowed for a transfer strobe
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire bio_pkg::bio_bus_in_t bus_in,
  output logic [7:0]              in_data_o,
  output logic [7:0]              in_data_oe_n,
  input  wire logic               err_event,
  output logic [7:0]              out_data,
  output logic                    out_strobe,
  output logic [7:0]              func_byte,
  output logic [2:0]              func_code,
  output logic                    func_strobe,
  output bio_pkg::bio_block_t     block,
  output logic                    end_irq,
  output logic                    ext_irq
);

  // refuse parameters the logic cannot serve
  if (DEV_ADDR >= `BIO_ADDR_RESERVED) begin : g_bad_addr
    $error("device address lies in the reserved range");
  end
  if (DO_WAIT_CYC < 2 || DO_WAIT_CYC > 255) begin : g_bad_wait
    $error("transfer wait count out of range");
  end

  // last count of the late-strobe timer
  localparam logic [7:0] WAIT_LIM = 8'(DO_WAIT_CYC);

  bio_pkg::bio_state_t st;        // registered state
  bio_pkg::bio_state_t next_st;   // next state

  // one builder serves the bus drivers and the apb read, so both agree
  // status byte as driven onto the input lines
  function automatic logic [7:0] status_byte(input bio_pkg::bio_state_t s);
    status_byte = {s.dev_bits, s.error, s.output_flag, s.input_flag, s.ready};
  endfunction

  // mapped register decode, used for read and write
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == `BIO_REG_CTRL) || (a == `BIO_REG_STATUS) || (a == `BIO_REG_OUT_DATA) ||
                (a == `BIO_REG_IN_DATA) || (a == `BIO_REG_FUNC) || (a == `BIO_REG_CMD);
  endfunction

  // block orders 2, 3, 6 and 7
  function automatic logic is_block(input bio_pkg::bio_order_t o);
    is_block = o[1];
  endfunction

  // unmapped offsets read as zero; the error answer is raised separately
  // read word for a register
  function automatic logic [31:0] rd_word(input bio_pkg::bio_state_t s, input logic [7:0] a);
    rd_word = 32'h0000_0000;
    case (a)
      `BIO_REG_CTRL: begin
        rd_word[`BIO_CTRL_ADDR_LSB +: 5]  = s.dev_addr;
        rd_word[`BIO_CTRL_READY_BIT]      = s.ready;
        rd_word[`BIO_CTRL_DEVB_LSB +: 4]  = s.dev_bits;
        rd_word[`BIO_CTRL_FMASK_LSB +: 8] = s.func_mask;
      end
      `BIO_REG_STATUS:   rd_word = {16'h0000, s.blk, s.order, s.connected, status_byte(s)};
      `BIO_REG_OUT_DATA: rd_word = {24'h000000, s.out_byte};
      `BIO_REG_IN_DATA:  rd_word = {24'h000000, s.in_byte};
      `BIO_REG_FUNC:     rd_word = {21'h000000, s.func_code, s.func_byte};
      default:           rd_word = 32'h0000_0000;
    endcase
  endfunction

  // edge and level terms from the synchronised strobes
  logic                co_fall;   // control strobe went low
  logic                do_fall;   // data output strobe went low
  logic                do_rise;   // data output strobe went high
  logic                di_rise;   // data input strobe went high
  logic                di_low;    // data input strobe held low
  logic                hit;       // control byte names this controller
  logic                in_reset;  // master reset line held low
  logic                apb_wr;    // write taken this edge
  logic                timeout;   // transfer strobe late
  logic                err_set;   // any error source
  bio_pkg::bio_order_t ord;       // order field of the bus byte
  logic [7:0]          bus_byte;  // true bus byte

  // only the second stage and the history stage are looked at
  assign co_fall  = st.prev.co_n & ~st.s2.co_n;
  assign do_fall  = st.prev.do_n & ~st.s2.do_n;
  assign do_rise  = ~st.prev.do_n & st.s2.do_n;
  assign di_rise  = ~st.prev.di_n & st.s2.di_n;
  assign di_low   = ~st.s2.di_n;
  assign in_reset = ~st.s2.master_reset_n_n;
  // data is settled ahead of the strobe, so it is synchronised in step
  assign bus_byte = ~st.s2.data_n;
  assign ord      = bio_pkg::bio_order_t'(bus_byte[7:5]);
  // compare is taken only on the true control strobe
  assign hit      = co_fall & ~st.s2.co_n & (bus_byte[4:0] == st.dev_addr);
  assign apb_wr   = psel & penable & pwrite & is_mapped(paddr);
  // only a transfer strobe or the master reset line disconnects; a late strobe only flags an error
  assign timeout  = st.connected & (st.timer == WAIT_LIM - 8'h01);
  // error sources: late-strobe timer, device pin and a software set
  assign err_set  = err_event | timeout |
                    (apb_wr & (paddr == `BIO_REG_CMD) & pwdata[`BIO_CMD_ERROR_BIT]);

  // next state
  always_comb begin
    next_st = st;
    // every bus line, data included, passes the same two stages
    // two-stage synchroniser and history for edge detection
    next_st.s1         = bus_in;
    next_st.s2         = st.s1;
    next_st.prev       = st.s2;
    next_st.func_pulse = 1'b0;
    next_st.out_pulse  = 1'b0;
    next_st.end_irq    = 1'b0;
    next_st.ext_irq    = 1'b0;

    // capturing in setup keeps prdata on a flop, so the access phase
    // answers at once with no wait state
    // apb setup phase captures read data and the error answer
    if (psel && !penable) begin
      next_st.prdata  = pwrite ? 32'h0000_0000 : rd_word(st, paddr);
      next_st.pslverr = ~is_mapped(paddr);
    end

    // wait counter for the transfer strobe; it holds at zero until the
    // control strobe's rise is seen, so the count spans only the gap
    // before the transfer strobe; a strobe DO_WAIT_CYC cycles after that rise is already late
    if (!st.connected || !st.s2.co_n || !st.prev.co_n || !st.s2.do_n || di_low) begin
      next_st.timer = 8'h00;
    end else if (st.timer != WAIT_LIM) begin
      next_st.timer = st.timer + 8'h01;
    end

    // control byte phase: connect and decode the order
    if (hit) begin
      next_st.connected = 1'b1;
      next_st.order     = ord;
      next_st.timer     = 8'h00;
      if (is_block(ord)) begin
        // either instruction direction starts a block
        next_st.blk.active     = 1'b1;
        next_st.blk.dir_out    = ord[2];
        next_st.blk.irq_at_end = ord[0];
      end else if (ord == bio_pkg::bio_ord_stop) begin
        if (st.blk.active && st.blk.irq_at_end) begin
          next_st.ext_irq = 1'b1;
        end
        next_st.blk.active  = 1'b0;
        next_st.blk.protect = 1'b0;
      end else if (ord == bio_pkg::bio_ord_protect) begin
        next_st.blk.protect = 1'b1;
      end
    end else if (st.connected && (do_rise || di_rise)) begin
      // one transfer strobe ends the service
      next_st.connected = 1'b0;
    end

    // other orders take the strobe and disconnect but store nothing
    // data output phase: gate is connect flag and data strobe
    if (st.connected && do_fall) begin
      if (st.func_mask[st.order]) begin
        // function order, data byte kept as extra parameter
        next_st.func_code  = st.order;
        next_st.func_byte  = bus_byte;
        next_st.func_pulse = 1'b1;
      end else if (st.order == bio_pkg::bio_ord_data) begin
        next_st.out_byte    = bus_byte;
        next_st.out_pulse   = 1'b1;
        next_st.output_flag = 1'b0;
      end
    end

    // data input phase completes
    if (st.connected && di_rise) begin
      if (st.order == bio_pkg::bio_ord_data) begin
        next_st.input_flag = 1'b0;
      end else if (st.order == bio_pkg::bio_ord_status) begin
        next_st.error = 1'b0;
      end
    end

    // input line drivers on only while connected and strobed
    next_st.drive_n = 8'hff;
    if (st.connected && di_low) begin
      if (st.order == bio_pkg::bio_ord_status) begin
        next_st.drive_n = ~status_byte(st);
      end else if (st.order == bio_pkg::bio_ord_data) begin
        next_st.drive_n = ~st.in_byte;
      end
    end

    // software writes, sets placed after hardware clears
    if (apb_wr) begin
      case (paddr)
        `BIO_REG_CTRL: begin
          if (pwdata[`BIO_CTRL_ADDR_LSB +: 5] < `BIO_ADDR_RESERVED) begin
            next_st.dev_addr = pwdata[`BIO_CTRL_ADDR_LSB +: 5];
          end
          next_st.ready     = pwdata[`BIO_CTRL_READY_BIT];
          next_st.dev_bits  = pwdata[`BIO_CTRL_DEVB_LSB +: 4];
          next_st.func_mask = (pwdata[`BIO_CTRL_FMASK_LSB +: 8] | `BIO_FMASK_FORCE_SET) &
                              ~`BIO_FMASK_FORCE_CLR;
        end
        `BIO_REG_OUT_DATA: next_st.output_flag = 1'b1;
        `BIO_REG_IN_DATA: begin
          next_st.in_byte    = pwdata[7:0];
          next_st.input_flag = 1'b1;
        end
        // block end comes from the memory side, raised here by software
        `BIO_REG_CMD: begin
          if (pwdata[`BIO_CMD_BLK_END_BIT] && st.blk.active) begin
            next_st.end_irq     = st.blk.irq_at_end;
            next_st.blk.active  = 1'b0;
            next_st.blk.protect = 1'b0;
          end
        end
        default: next_st.ready = st.ready;
      endcase
    end

    // an error arriving with the status read still sticks
    if (err_set) begin
      next_st.error = 1'b1;
    end

    // the bus reset goes through the synchroniser too, so it acts two cycles late
    // master reset line returns the control flip-flops
    if (in_reset) begin
      next_st.connected = 1'b0;
      next_st.order     = bio_pkg::bio_ord_data;
      next_st.blk       = '0;
      next_st.timer     = 8'h00;
      next_st.drive_n   = 8'hff;
      next_st.error     = 1'b0;
      next_st.ext_irq   = 1'b0;
      next_st.end_irq   = 1'b0;
    end
  end

  // synchroniser stages reset to the idle high level, so release shows no false edge
  // state register, constants only under reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st           <= '0;
      st.s1        <= '1;
      st.s2        <= '1;
      st.prev      <= '1;
      st.drive_n   <= 8'hff;
      st.dev_addr  <= DEV_ADDR;
      st.func_mask <= `BIO_FMASK_RESET;
    end else begin
      st <= next_st;
    end
  end

  // outputs
  // pready is tied high: every transfer is one setup and one access cycle
  // open-collector input lines: the value stays low, only the enable moves
  assign prdata       = st.prdata;
  assign pready       = 1'b1;
  assign pslverr      = st.pslverr & psel & penable;
  assign in_data_o    = 8'h00;
  assign in_data_oe_n = st.drive_n;
  assign out_data     = st.out_byte;
  assign out_strobe   = st.out_pulse;
  assign func_byte    = st.func_byte;
  assign func_code    = st.func_code;
  assign func_strobe  = st.func_pulse;
  assign block        = st.blk;
  assign end_irq      = st.end_irq;
  assign ext_irq      = st.ext_irq;

  // checks
  // the strobes reach the state two cycles late, so checks look at the
  // synchronised copies and the registered state; only sync_delay_a looks back at the co_n pin
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  connect_on_match_a: assert property (hit && !in_reset |=> st.connected)
    else $error("no connect after address match");
  order_kept_a: assert property (hit && !in_reset |=> st.order == $past(ord))
    else $error("order not stored");
  no_stray_connect_a: assert property (!st.connected && !hit |=> !st.connected)
    else $error("connected without a match");
  stay_connected_a: assert property (st.connected && !do_rise && !di_rise && !in_reset
                                     |=> st.connected)
    else $error("dropped service early");
  disconnect_a: assert property (st.connected && (do_rise || di_rise) && !hit && !in_reset
                                 |=> !st.connected)
    else $error("no disconnect on strobe rise");
  data_latch_a: assert property (st.connected && do_fall && st.order == bio_pkg::bio_ord_data
                                 |=> out_strobe && out_data == $past(bus_byte))
    else $error("data byte not latched");
  func_out_a: assert property (st.connected && do_fall && st.func_mask[st.order]
                               |=> func_strobe && func_code == $past(st.order))
    else $error("function not issued");
  no_data_func_a: assert property (st.func_mask[0] == 1'b0 && st.func_mask[1])
    else $error("function mask holds data code");
  status_drive_a: assert property (st.connected && di_low && !in_reset &&
                                   st.order == bio_pkg::bio_ord_status
                                   |=> in_data_oe_n == $past(~status_byte(st)))
    else $error("status byte not driven");
  error_clear_a: assert property (st.connected && di_rise && !err_set && !in_reset &&
                                  st.order == bio_pkg::bio_ord_status |=> !st.error)
    else $error("error not cleared by status read");
  block_start_a: assert property (hit && is_block(ord) && !in_reset
                                  |=> block.active && block.dir_out == $past(ord[2]))
    else $error("block transfer not started");
  stop_irq_a: assert property (hit && ord == bio_pkg::bio_ord_stop && st.blk.active &&
                               st.blk.irq_at_end && !in_reset
                               |=> ext_irq && !block.active)
    else $error("stop did not interrupt");
  protect_end_a: assert property ($fell(block.active) |-> !block.protect)
    else $error("protect kept after transfer end");
  master_reset_n_clear_a: assert property (in_reset |=> !st.connected && !block.active)
    else $error("master reset left state");
  sync_delay_a: assert property ($rose(st.connected) |-> !$past(bus_in.co_n, 3))
    else $error("connect ahead of synchronised strobe");

  // invariants, one-cycle pulses and the late-strobe error
  late_error_a: assert property (timeout && !in_reset |=> st.error)
    else $error("late transfer strobe not flagged");
  drivers_off_a: assert property (!st.connected |=> in_data_oe_n == 8'hff)
    else $error("input lines driven while not connected");
  out_hold_a: assert property (!out_strobe |-> $stable(out_data))
    else $error("data register changed without a strobe");
  func_single_a: assert property (func_strobe |=> !func_strobe)
    else $error("function strobe longer than one cycle");
  ext_only_stop_a: assert property (ext_irq |-> $past(hit && ord == bio_pkg::bio_ord_stop))
    else $error("external interrupt without a stop order");
  addr_legal_a: assert property (st.dev_addr < `BIO_ADDR_RESERVED)
    else $error("device address in the reserved range");

endmodule // bio_byte_io_dev

`default_nettype wire

// File: testbench/bio_bus_master.sv
// processor-side model of the byte i/o bus: strobes and output data lines
// assumes a 40 ns pclk; every bus line is active low
`timescale 1ns/1ps
`default_nettype none

module bio_bus_master (
  input  wire logic                 pclk,
  output var  bio_pkg::bio_bus_in_t bus,
  input  wire logic [7:0]           in_data_o,
  input  wire logic [7:0]           in_data_oe_n
);
  logic [7:0] in_wire;  // input lines, pulled up at this end
  assign in_wire = in_data_oe_n | in_data_o;

  // idle bus: strobes high, output lines all ones
  initial begin
    bus = '{co_n: 1'b1, do_n: 1'b1, di_n: 1'b1, master_reset_n_n: 1'b1, data_n: 8'hff};
  end

  // wait a number of rising edges
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // control byte, strobe 240 ns later for 880 ns, then lines released
  task automatic ctl_out(input logic [4:0] addr, input logic [2:0] order);
    tick(1);
    bus.data_n <= ~{order, addr};
    tick(6);
    bus.co_n <= 1'b0;
    tick(22);
    bus.co_n <= 1'b1;
    bus.data_n <= {order, addr};  // released lines show the inverse
  endtask

  // data byte; its strobe starts gap cycles after the control byte left
  task automatic data_out(input logic [7:0] b, input int gap);
    tick(gap - 6);
    bus.data_n <= ~b;
    tick(6);
    bus.do_n <= 1'b0;
    tick(22);
    bus.do_n <= 1'b1;
    bus.data_n <= b;
  endtask

  // input strobe for 880 ns; byte taken 440 ns in
  task automatic data_in(output logic [7:0] b, input int gap);
    tick(gap);
    bus.di_n <= 1'b0;
    tick(11);
    b = ~in_wire;
    tick(11);
    bus.di_n <= 1'b1;
  endtask

  // master reset line low for four cycles
  task automatic pulse_reset();
    tick(1);
    bus.master_reset_n_n <= 1'b0;
    tick(4);
    bus.master_reset_n_n <= 1'b1;
  endtask
endmodule // bio_bus_master
`default_nettype wire

// File: testbench/test_byte_io_bus_device_controller.sv
// self-checking bench for the byte i/o device controller
// assumes the bus model in bio_bus_master.sv and a 40 ns pclk
`timescale 1ns/1ps
`include "bio_defs.svh"
`default_nettype none

module test_byte_io_bus_device_controller;
  localparam logic [4:0] DEV = 5'h05;  // bus address set by software
  localparam logic [3:0] DVB = 4'h5;   // device-specific status bits
  logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]           paddr;
  logic [31:0]          pwdata, prdata;
  bio_pkg::bio_bus_in_t bus_in;         // bus lines from the model
  logic [7:0]           in_data_o, in_data_oe_n, out_data, func_byte;
  logic                 err_event, out_strobe, func_strobe, end_irq, ext_irq;
  logic [2:0]           func_code, o;
  bio_pkg::bio_block_t  block;
  logic [31:0]          rd;             // last apb read data
  logic                 er;             // last apb error flag
  logic [7:0]           b;              // byte moved on the bus
  int                   n_errors = 0, compares = 0, n0, gap;
  int                   n_out = 0, n_func = 0, n_end = 0, n_ext = 0;
  integer               seed = 32'hc8cb;

  bio_byte_io_dev #(.DEV_ADDR(5'h01), .DO_WAIT_CYC(110)) i_bio_byte_io_dev (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .bus_in, .in_data_o, .in_data_oe_n, .err_event, .out_data, .out_strobe,
    .func_byte, .func_code, .func_strobe, .block, .end_irq, .ext_irq);
  bio_bus_master i_bio_bus_master (.pclk, .bus(bus_in), .in_data_o, .in_data_oe_n);

  // 25 MHz clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // count the one-cycle pulses
  always @(posedge pclk) begin
    if (out_strobe === 1'b1) n_out <= n_out + 1;
    if (func_strobe === 1'b1) n_func <= n_func + 1;
    if (end_irq === 1'b1) n_end <= n_end + 1;
    if (ext_irq === 1'b1) n_ext <= n_ext + 1;
  end

  // expected control word for an address
  function automatic logic [31:0] ctrl_val(input logic [4:0] a);
    return {8'h0, 8'h02, DVB, 3'h0, 1'b1, 3'h0, a};
  endfunction

  // expected status byte, device ready
  function automatic logic [7:0] exp_status(input logic e, input logic of, input logic inf);
    return {DVB, e, of, inf, 1'b1};
  endfunction

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer: setup, access held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // verdict and end of run
  task automatic tally_and_finish();
    if (n_errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    tally_and_finish();
  end

  // main sequence
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, err_event} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    chk(32'(block), 32'h0);
    chk(32'(in_data_oe_n), 32'hff);
    apb(1'b1, `BIO_REG_CTRL, ctrl_val(DEV));
    apb(1'b1, `BIO_REG_CTRL, ctrl_val(5'h16));
    apb(1'b0, `BIO_REG_CTRL, 32'h0);
    chk(rd, ctrl_val(DEV));
    apb(1'b0, 8'h18, 32'h0);
    chk(32'(er), 32'h1);
    // data output: boundary bytes and gaps, then random
    for (int i = 0; i < 8; i++) begin
      b = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
      gap = (i == 1) ? 104 : 22 + ($random(seed) & 63);
      n0 = n_out;
      i_bio_bus_master.ctl_out(DEV, 3'd0);
      i_bio_bus_master.data_out(b, gap);
      repeat (4) @(posedge pclk);
      chk(32'(n_out - n0), 32'h1);
      chk(32'(out_data), 32'(b));
      apb(1'b0, `BIO_REG_STATUS, 32'h0);
      chk(32'(rd[8]), 32'h0);
    end
    // another address on the bus is ignored
    n0 = n_out;
    i_bio_bus_master.ctl_out(DEV ^ 5'h01, 3'd0);
    i_bio_bus_master.data_out(~b, 22);
    repeat (4) @(posedge pclk);
    chk(32'(n_out - n0), 32'h0);
    // function output keeps its byte, data register untouched
    n0 = n_func;
    i_bio_bus_master.ctl_out(DEV, 3'd1);
    i_bio_bus_master.data_out(8'hc3, 40);
    repeat (4) @(posedge pclk);
    chk(32'(n_func - n0), 32'h1);
    chk(32'({func_code, func_byte}), 32'h1c3);
    chk(32'(out_data), 32'(b));
    // status input with every flag up, then error cleared
    apb(1'b1, `BIO_REG_OUT_DATA, 32'h0);
    apb(1'b1, `BIO_REG_IN_DATA, 32'h3c);
    err_event <= 1'b1;
    @(posedge pclk);
    err_event <= 1'b0;
    i_bio_bus_master.ctl_out(DEV, 3'd1);
    i_bio_bus_master.data_in(b, 22);
    chk(32'(b), 32'(exp_status(1'b1, 1'b1, 1'b1)));
    repeat (4) @(posedge pclk);
    chk(32'(in_data_oe_n), 32'hff);
    i_bio_bus_master.ctl_out(DEV, 3'd1);
    i_bio_bus_master.data_in(b, 22);
    chk(32'(b[3]), 32'h0);
    i_bio_bus_master.ctl_out(DEV, 3'd0);
    i_bio_bus_master.data_in(b, 60);
    chk(32'(b), 32'h3c);
    // block orders 2, 3, 6, 7 and their end
    for (int k = 0; k < 4; k++) begin
      o = {k[1], 1'b1, k[0]};
      n0 = n_end;
      i_bio_bus_master.ctl_out(DEV, o);
      repeat (2) @(posedge pclk);
      chk(32'(block), 32'({1'b1, o[2], o[0], 1'b0}));
      apb(1'b1, `BIO_REG_CMD, 32'h1);
      repeat (3) @(posedge pclk);
      chk(32'(n_end - n0), 32'(o[0]));
      chk(32'(block), 32'({1'b0, o[2], o[0], 1'b0}));
    end
    // stop: interrupt only for an interrupting block
    for (int k = 0; k < 2; k++) begin
      n0 = n_ext;
      i_bio_bus_master.ctl_out(DEV, k ? 3'd3 : 3'd2);
      i_bio_bus_master.ctl_out(DEV, 3'd4);
      repeat (2) @(posedge pclk);
      chk(32'(n_ext - n0), 32'(k));
      chk(32'(block), 32'(k * 2));
    end
    // protect mode until the transfer ends
    i_bio_bus_master.ctl_out(DEV, 3'd2);
    i_bio_bus_master.ctl_out(DEV, 3'd5);
    repeat (2) @(posedge pclk);
    chk(32'(block), 32'h9);
    apb(1'b1, `BIO_REG_CMD, 32'h1);
    repeat (2) @(posedge pclk);
    chk(32'(block), 32'h0);
    // master reset line clears block and connection
    i_bio_bus_master.ctl_out(DEV, 3'd7);
    i_bio_bus_master.pulse_reset();
    repeat (4) @(posedge pclk);
    chk(32'(block), 32'h0);
    apb(1'b0, `BIO_REG_STATUS, 32'h0);
    chk(32'(rd[8]), 32'h0);
    chk(32'(rd[3]), 32'h0);
    // no transfer strobe in time: error set, service kept
    i_bio_bus_master.ctl_out(DEV, 3'd0);
    repeat (120) @(posedge pclk);
    apb(1'b0, `BIO_REG_STATUS, 32'h0);
    chk(32'({rd[8], rd[3]}), 32'h3);
    tally_and_finish();
  end
endmodule // test_byte_io_bus_device_controller
`default_nettype wire
